// ==== hdl/afap_defs.svh ====
// Register offsets, field positions and values for the accelerometer output block.
`ifndef AFAP_DEFS_SVH
`define AFAP_DEFS_SVH
`define AFAP_OFS_STATUS 7'h11
`define AFAP_OFS_FIFO_DATA 7'h1D
`define AFAP_OFS_CNT_LO 7'h1E
`define AFAP_OFS_CNT_HI 7'h1F
`define AFAP_OFS_CLK 7'h25
`define AFAP_OFS_MODE 7'h26
`define AFAP_OFS_CHEN 7'h27
`define AFAP_OFS_LPBUS 7'h28
`define AFAP_OFS_NVM 7'h29
`define AFAP_OFS_SRST 7'h2A
`define AFAP_OFS_IRQMAP 7'h2B
`define AFAP_OFS_FCFGA 7'h30
`define AFAP_OFS_FCFGB 7'h31
`define AFAP_OFS_SPA 7'h32
`define AFAP_OFS_SPB 7'h33
`define AFAP_OFS_SPC 7'h34
`define AFAP_OFS_SYNC 7'h35
`define AFAP_OFS_PDM 7'h36
`define AFAP_OFS_DECIM 7'h49
`define AFAP_OFS_FILT 7'h50
`define AFAP_OFS_DRV0 7'h59
`define AFAP_OFS_DRV1 7'h5A
`define AFAP_OFS_DRV2 7'h5C
`define AFAP_RST_VAL 8'h00
`define AFAP_BIT_CH_X 6
`define AFAP_BIT_CH_Y 5
`define AFAP_BIT_CH_Z 4
`define AFAP_BIT_FIFO_EN 3
`define AFAP_BIT_DBL 2
`define AFAP_BIT_TAG 6
`define AFAP_BIT_STREAM 5
`define AFAP_BIT_THR_HI 0
`define AFAP_BIT_WM 3
`define AFAP_BIT_SYNC_EXT 7
`define AFAP_BIT_SYNC_MODE 4
`define AFAP_BIT_SPA_PULSE 3
`define AFAP_BIT_SLOT_X 7
`define AFAP_BIT_EQ_OFF 6
`define AFAP_BIT_DECIM_BYP 7
`define AFAP_MODE_STANDBY 4'h0
`define AFAP_MODE_HS 4'h1
`define AFAP_MODE_HP 4'hC
`define AFAP_MODE_RBW 4'hB
`define AFAP_MODE_LP 4'hA
`define AFAP_BIT_AUDIO 4
`define AFAP_BIT_PDM 5
`define AFAP_SRC_EXT 2'h2
`define AFAP_DIV4 4'h3
`define AFAP_DIV8 4'h5
`define AFAP_FIFO_DEPTH 9'h1FF
`define AFAP_ODR_CNT 8'h10
`endif

// ==== hdl/afap_pkg.sv ====
// Types shared by the accelerometer output block.
package afap_pkg;
  typedef struct packed {
    logic [1:0] axis;
    logic [13:0] value;
  } afap_entry_t;
  typedef enum logic [1:0] {
    AFAP_RD_IDLE = 2'b00,
    AFAP_RD_BUSY = 2'b01
  } afap_rd_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } afap_req_t;
endpackage : afap_pkg

// ==== hdl/afap_core.sv ====
// Sample FIFO, clock divider, audio port framing and mode register file.
//
// Overview of operation
// - 0x78 enables axes and FIFO; standby stores nothing
// - 0x60 turns on tagging; stream bit is stored but FIFO still stops when full
// - Nine-bit threshold split across FIFO config registers
// - Level flag status bit 3; map drives pin
// - High performance mode starts FIFO accumulation
// - Burst reads of read port pop entries
// - Sample arriving during FIFO read is dropped
// - Divide ratio field divides bit clock to system
// - Source select chooses internal or external clock
// - Port config A selects stereo or pulse sync
// - Config B bit 7 picks live x, else held z, for the slot
// - Config C is stored only; z is sent when B bit 7 is clear
// - Sync setup 0x80 makes frame sync an external input except in density mode
// - Decimation setup bit 7 drives the filter bypass output
// - Filter config disables equaliser stage
// - Channel enable bit 2 doubles rate
// - Mode values pick audio, density or heart
// - Density mode bypasses filters, assigns slots
// - Sync mode locks rate only in sigma-delta modes
// - Heart sound mode uses z channel only
`timescale 1ns/1ps
`include "afap_defs.svh"
module afap_core (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic cs_n_i,
  input wire logic bclk_i,
  input wire logic frame_pin_drive_i,
  input wire logic sync_i,
  input wire logic [13:0] accel_x_i,
  input wire logic [13:0] accel_y_i,
  input wire logic [13:0] accel_z_i,
  output logic [7:0] reg_rdata_o,
  output logic irq0_o,
  output logic sys_tick_o,
  output logic dout_o,
  output logic frame_pin_drive_o,
  output logic frame_pin_drive_oe_o,
  output logic eq_bypass_o,
  output logic filt_bypass_o,
  output logic double_rate_o
);
  logic rst_s1_q;
  logic rst_n;
  logic [2:0] bclk_sync_q;
  logic [1:0] frame_pin_drive_sync_q;
  logic fs_lvl_q;
  logic [2:0] sync_sync_q;
  logic [1:0] cs_sync_q;
  logic [7:0] regs_q [0:127];
  logic [7:0] chen;
  logic [7:0] opm;
  logic [7:0] clkc;
  logic [8:0] thresh;
  logic [8:0] count_q;
  logic [8:0] wr_ptr_q;
  logic [8:0] rd_ptr_q;
  logic [15:0] mem_q [0:511];
  logic [7:0] rd_byte_q;
  logic rd_hi_q;
  afap_pkg::afap_rd_state_t rd_st_q;
  logic [1:0] axis_q;
  logic [7:0] odr_cnt_q;
  logic [3:0] div_cnt_q;
  logic [3:0] div_lim;
  logic ext_clk;
  logic bclk_rise;
  logic frame_pin_drive_rise;
  logic sync_rise;
  logic sample_tick;
  logic meas_mode;
  logic fifo_on;
  logic push;
  logic pop;
  logic full;
  logic empty;
  logic wm;
  logic sd_mode;
  logic [13:0] axis_val;
  logic [2:0] ax_en;
  logic [1:0] next_axis;
  logic [5:0] bit_cnt_q;
  logic [31:0] shift_q;
  logic [13:0] last_z_q;
  logic reg_wr_ok;
  logic [7:0] rd_mux;
  logic [15:0] top_entry;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // The second stage feeds each edge detector, against the third stage or, for frame sync, the level held at the last bit clock rise.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bclk_sync_q <= 3'h0;
      frame_pin_drive_sync_q <= 2'h0;
      fs_lvl_q <= 1'b0;
      sync_sync_q <= 3'h0;
      cs_sync_q <= 2'h3;
    end
    else
    begin
      bclk_sync_q <= {bclk_sync_q[1:0], bclk_i};
      frame_pin_drive_sync_q <= {frame_pin_drive_sync_q[0], frame_pin_drive_i};
      if (bclk_rise)
        fs_lvl_q <= frame_pin_drive_sync_q[1];
      sync_sync_q <= {sync_sync_q[1:0], sync_i};
      cs_sync_q <= {cs_sync_q[0], cs_n_i};
    end
  end

  assign chen = regs_q[`AFAP_OFS_CHEN];
  assign opm = regs_q[`AFAP_OFS_MODE];
  assign clkc = regs_q[`AFAP_OFS_CLK];
  assign thresh = {regs_q[`AFAP_OFS_FCFGA][`AFAP_BIT_THR_HI], regs_q[`AFAP_OFS_FCFGB]};
  assign bclk_rise = bclk_sync_q[1] & ~bclk_sync_q[2];
  // Frame start is the first bit clock rise that finds frame sync high.
  assign frame_pin_drive_rise = frame_pin_drive_sync_q[1] & ~fs_lvl_q;
  assign sync_rise = sync_sync_q[1] & ~sync_sync_q[2];
  assign ext_clk = (clkc[1:0] == `AFAP_SRC_EXT);
  assign div_lim = (clkc[7:4] == `AFAP_DIV8) ? 4'h7 : (clkc[7:4] == `AFAP_DIV4) ? 4'h3 : 4'h0;
  assign meas_mode = (opm[3:0] != `AFAP_MODE_STANDBY);
  assign sd_mode = (opm[3:0] == `AFAP_MODE_HP) | (opm[3:0] == `AFAP_MODE_RBW)
                 | (opm[3:0] == `AFAP_MODE_LP);
  assign fifo_on = chen[`AFAP_BIT_FIFO_EN] & meas_mode;
  assign ax_en = (opm[3:0] == `AFAP_MODE_HS) ? {2'b00, chen[`AFAP_BIT_CH_Z]}
               : {chen[`AFAP_BIT_CH_X], chen[`AFAP_BIT_CH_Y], chen[`AFAP_BIT_CH_Z]};
  assign axis_val = (axis_q == 2'h0) ? accel_x_i : (axis_q == 2'h1) ? accel_y_i : accel_z_i;
  assign full = (count_q == `AFAP_FIFO_DEPTH);
  assign empty = (count_q == 9'h000);
  assign wm = (count_q >= thresh) & (thresh != 9'h000);
  // A sample landing while a burst read runs is lost on purpose.
  assign push = sample_tick & fifo_on & ax_en[2'h2 - axis_q] & ~full
              & (rd_st_q == afap_pkg::AFAP_RD_IDLE);
  assign pop = reg_rd_i & (reg_addr_i == `AFAP_OFS_FIFO_DATA) & rd_hi_q & ~empty;
  assign next_axis = (axis_q == 2'h2) ? 2'h0 : axis_q + 2'h1;
  assign top_entry = mem_q[rd_ptr_q];
  assign reg_wr_ok = reg_wr_i & (reg_addr_i != `AFAP_OFS_STATUS)
                   & (reg_addr_i[6:2] != 5'h07);
  assign double_rate_o = chen[`AFAP_BIT_DBL];
  assign eq_bypass_o = regs_q[`AFAP_OFS_FILT][`AFAP_BIT_EQ_OFF];
  assign filt_bypass_o = opm[`AFAP_BIT_PDM] | regs_q[`AFAP_OFS_DECIM][`AFAP_BIT_DECIM_BYP];
  assign frame_pin_drive_oe_o = ~regs_q[`AFAP_OFS_SYNC][`AFAP_BIT_SYNC_EXT] | opm[`AFAP_BIT_PDM];

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt_q <= 4'h0;
    else if (!ext_clk || div_cnt_q >= div_lim)
      div_cnt_q <= (ext_clk && bclk_rise) || !ext_clk ? 4'h0 : div_cnt_q;
    else if (bclk_rise)
      div_cnt_q <= div_cnt_q + 4'h1;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      sys_tick_o <= 1'b0;
    else
      sys_tick_o <= ext_clk ? (bclk_rise & (div_cnt_q >= div_lim)) : 1'b1;
  end

  // Samples step through x, y, z on each rate tick; external sync overrides.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      odr_cnt_q <= 8'h00;
      sample_tick <= 1'b0;
      axis_q <= 2'h0;
    end
    else
    begin
      if (regs_q[`AFAP_OFS_SYNC][`AFAP_BIT_SYNC_MODE] && sd_mode)
        sample_tick <= sync_rise;
      else if (sys_tick_o && odr_cnt_q == `AFAP_ODR_CNT)
        sample_tick <= 1'b1;
      else
        sample_tick <= 1'b0;
      if (sys_tick_o)
        odr_cnt_q <= (odr_cnt_q == `AFAP_ODR_CNT) ? 8'h00 : odr_cnt_q + 8'h01;
      if (sample_tick)
        axis_q <= next_axis;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (push)
      mem_q[wr_ptr_q] <= {axis_q, axis_val};
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= 9'h000;
      rd_ptr_q <= 9'h000;
      count_q <= 9'h000;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 9'h001;
      if (pop)
        rd_ptr_q <= rd_ptr_q + 9'h001;
      count_q <= count_q + {8'h00, push} - {8'h00, pop};
    end
  end

  // Each entry is two bytes: tag and high value bits first, then low bits.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_st_q <= afap_pkg::AFAP_RD_IDLE;
      rd_hi_q <= 1'b0;
      rd_byte_q <= 8'h00;
    end
    else
    begin
      case (rd_st_q)
        afap_pkg::AFAP_RD_IDLE:
          if (reg_rd_i && reg_addr_i == `AFAP_OFS_FIFO_DATA && !cs_sync_q[1])
            rd_st_q <= afap_pkg::AFAP_RD_BUSY;
        afap_pkg::AFAP_RD_BUSY:
          if (cs_sync_q[1])
            rd_st_q <= afap_pkg::AFAP_RD_IDLE;
        default:
          rd_st_q <= afap_pkg::AFAP_RD_IDLE;
      endcase
      if (cs_sync_q[1])
        rd_hi_q <= 1'b0;
      else if (reg_rd_i && reg_addr_i == `AFAP_OFS_FIFO_DATA)
        rd_hi_q <= ~rd_hi_q;
      rd_byte_q <= rd_hi_q ? top_entry[7:0]
                 : (regs_q[`AFAP_OFS_FCFGA][`AFAP_BIT_TAG] ? {top_entry[15:14], top_entry[13:8]}
                 : {2'b00, top_entry[13:8]});
    end
  end

  // Software writes land in the register array; status reads show live state.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 128; i++)
        regs_q[i] <= `AFAP_RST_VAL;
    end
    else if (reg_wr_ok)
      regs_q[reg_addr_i] <= reg_wdata_i;
  end

  assign rd_mux = (reg_addr_i == `AFAP_OFS_STATUS) ? {4'h0, wm, 3'h0}
                : (reg_addr_i == `AFAP_OFS_FIFO_DATA) ? (empty ? 8'h00 : rd_byte_q)
                : (reg_addr_i == `AFAP_OFS_CNT_LO) ? count_q[7:0]
                : (reg_addr_i == `AFAP_OFS_CNT_HI) ? {7'h00, count_q[8]}
                : regs_q[reg_addr_i];

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_o <= 8'h00;
      irq0_o <= 1'b0;
    end
    else
    begin
      reg_rdata_o <= reg_rd_i ? rd_mux : reg_rdata_o;
      irq0_o <= wm & regs_q[`AFAP_OFS_IRQMAP][`AFAP_BIT_WM];
    end
  end

  // Audio serializer: one 32-bit word per frame, live x when the SPB slot bit is set, else the held z sample.
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt_q <= 6'h00;
      shift_q <= 32'h0000_0000;
      dout_o <= 1'b0;
      frame_pin_drive_o <= 1'b0;
      last_z_q <= 14'h0000;
    end
    else
    begin
      if (sample_tick && axis_q == 2'h2)
        last_z_q <= accel_z_i;
      if (opm[`AFAP_BIT_PDM])
      begin
        dout_o <= bclk_rise ? accel_x_i[13] ^ accel_y_i[13] : dout_o;
        frame_pin_drive_o <= bclk_rise ? accel_z_i[13] : frame_pin_drive_o;
      end
      else if (opm[`AFAP_BIT_AUDIO] && bclk_rise)
      begin
        if (frame_pin_drive_rise)
        begin
          bit_cnt_q <= 6'h00;
          shift_q <= {regs_q[`AFAP_OFS_SPB][`AFAP_BIT_SLOT_X] ? accel_x_i : last_z_q,
                      18'h00000};
        end
        else
        begin
          bit_cnt_q <= bit_cnt_q + 6'h01;
          shift_q <= {shift_q[30:0], 1'b0};
        end
        dout_o <= shift_q[31];
        frame_pin_drive_o <= regs_q[`AFAP_OFS_SPA][`AFAP_BIT_SPA_PULSE] ? (bit_cnt_q == 6'h1F)
                 : bit_cnt_q[5];
      end
    end
  end

  AST_COUNT_TRACK: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (push && !pop) |=> count_q == $past(count_q) + 9'h001)
    else $error("count did not rise");
  AST_EMPTY_POP: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    empty |-> !pop)
    else $error("pop from empty");
  AST_STANDBY: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    !meas_mode |-> !push)
    else $error("push in standby");
  AST_DROP: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (rd_st_q == afap_pkg::AFAP_RD_BUSY) |-> !push)
    else $error("push during read");
  AST_IRQ: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (wm && regs_q[`AFAP_OFS_IRQMAP][`AFAP_BIT_WM]) |=> irq0_o)
    else $error("irq missing");
  AST_WM: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (count_q < thresh) |-> !wm)
    else $error("early level flag");
  AST_HS_Z: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (push && opm[3:0] == `AFAP_MODE_HS) |-> axis_q == 2'h2)
    else $error("non z in heart mode");
  AST_INT_CLK: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    (!ext_clk && $past(!ext_clk)) |=> sys_tick_o)
    else $error("internal tick missing");
  COV_PUSH: cover property (@(posedge sys_clk_i) disable iff (!rst_n) push);
  COV_POP: cover property (@(posedge sys_clk_i) disable iff (!rst_n) pop);
  COV_IRQ: cover property (@(posedge sys_clk_i) disable iff (!rst_n) $rose(irq0_o));
endmodule : afap_core

// ==== bench/afap_host_model.sv ====
// Audio host model that supplies the bit clock, frame sync and sync pulse.
`timescale 1ns/1ps
module afap_host_model (
  input wire logic sys_clk_i,
  input wire logic en_i,
  output logic bclk_o,
  output logic frame_pin_drive_o,
  output logic sync_o
);
  logic [8:0] cnt_q;
  // The bit clock stands low while the host is idle.
  always_ff @(posedge sys_clk_i)
  begin
    if (!en_i)
    begin
      cnt_q <= 9'h000;
      bclk_o <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 9'h001;
      bclk_o <= cnt_q[2];
    end
    frame_pin_drive_o <= en_i & cnt_q[8];
    sync_o <= en_i && (cnt_q == 9'h080);
  end
endmodule : afap_host_model

// ==== bench/accel_fifo_audio_port_config_tb_top.sv ====
// Self-checking bench for the accelerometer output block.
`timescale 1ns/1ps
module accel_fifo_audio_port_config_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, cs_n = 1'b1, en = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00, rdata, b;
  logic bclk, fs, sy, irq, tick, dout, fso, fsoe, eqb, fb, dbl;
  logic [13:0] smp = 14'h1234;
  logic [13:0] w = 14'h0000;
  logic [1:0] tg = 2'h0;
  logic [6:0] zofs [4] = '{7'h27, 7'h28, 7'h29, 7'h2A};
  logic [6:0] rwofs [9] = '{7'h32, 7'h33, 7'h34, 7'h36, 7'h49, 7'h50, 7'h59, 7'h5A, 7'h5C};
  logic [7:0] ck [4] = '{8'h00, 8'h02, 8'h32, 8'h52};
  int ex [4] = '{320, 40, 10, 5};
  int n_fail = 0, n_tests = 0, cyc = 0, c, n;
  always #25 clk = ~clk;
  afap_host_model host (.sys_clk_i(clk), .en_i(en), .bclk_o(bclk), .frame_pin_drive_o(fs), .sync_o(sy));
  afap_core dut (.sys_clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .cs_n_i(cs_n), .bclk_i(bclk), .frame_pin_drive_i(fs),
    .sync_i(sy), .accel_x_i(smp), .accel_y_i(smp), .accel_z_i(smp), .reg_rdata_o(rdata),
    .irq0_o(irq), .sys_tick_o(tick), .dout_o(dout), .frame_pin_drive_o(fso), .frame_pin_drive_oe_o(fsoe),
    .eq_bypass_o(eqb), .filt_bypass_o(fb), .double_rate_o(dbl));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 wr = 1'b0;
    @(posedge clk);
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [6:0] a);
    rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1 rd = 1'b0;
    @(posedge clk);
    #1 b = rdata;
  endtask : rd_reg
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    foreach (zofs[k])
    begin
      rd_reg(zofs[k]);
      check("reset value", b, 8'h00);
    end
    foreach (rwofs[k])
    begin
      wr_reg(rwofs[k], {1'b0, rwofs[k]} ^ 8'hA5);
      rd_reg(rwofs[k]);
      check("read back", b, {1'b0, rwofs[k]} ^ 8'hA5);
    end
    wr_reg(7'h11, 8'hFF);
    rd_reg(7'h11);
    check("status write ignored", b, 8'h00);
    rd_reg(7'h7F);
    check("unmapped", b, 8'h00);
    wr_reg(7'h27, 8'h78);
    wr_reg(7'h30, 8'h60);
    wr_reg(7'h31, 8'h0C);
    wr_reg(7'h2B, 8'h08);
    repeat (100) @(posedge clk);
    #1 rd_reg(7'h1E);
    check("standby count", b, 8'h00);
    check("irq idle", irq, 1'b0);
    wr_reg(7'h26, 8'h0C);
    for (c = 0; c < 300 && irq !== 1'b1; c++)
    begin
      @(posedge clk);
      #1;
    end
    #1 check("irq level", irq, 1'b1);
    rd_reg(7'h11);
    check("level flag", b[3], 1'b1);
    wr_reg(7'h26, 8'h00);
    rd_reg(7'h1E);
    c = b;
    check("count at threshold", c >= 12, 1'b1);
    cs_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    for (n = 0; n < c; n++)
    begin
      rd_reg(7'h1D);
      check("entry high", b[5:0], smp[13:8]);
      if (n > 0) check("entry tag", b[7:6], (tg == 2'h2) ? 2'h0 : tg + 2'h1);
      tg = b[7:6];
      rd_reg(7'h1D);
      check("entry low", b, smp[7:0]);
    end
    #1 cs_n = 1'b1;
    rd_reg(7'h1E);
    check("drained count", b, 8'h00);
    rd_reg(7'h11);
    check("flag after drain", b[3], 1'b0);
    cs_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rd_reg(7'h1D);
    rd_reg(7'h1D);
    wr_reg(7'h26, 8'h0C);
    repeat (60) @(posedge clk);
    #1 rd_reg(7'h1E);
    check("dropped during read", b, 8'h00);
    cs_n = 1'b1;
    repeat (60) @(posedge clk);
    #1 rd_reg(7'h1E);
    check("filling after read", b != 8'h00, 1'b1);
    wr_reg(7'h26, 8'h00);
    en = 1'b1;
    foreach (ck[k])
    begin
      wr_reg(7'h25, ck[k]);
      repeat (20) @(posedge clk);
      n = 0;
      repeat (320)
      begin
        @(posedge clk);
        #1 if (tick === 1'b1) n++;
      end
      check("tick rate", n >= ex[k] - 1 && n <= ex[k] + 1, 1'b1);
    end
    wr_reg(7'h25, 8'h00);
    wr_reg(7'h32, 8'h00);
    wr_reg(7'h33, 8'h88);
    wr_reg(7'h26, 8'h1C);
    @(posedge fs);
    #1 @(negedge bclk);
    n = 0;
    for (c = 1; c <= 64; c++)
    begin
      @(negedge bclk);
      #1 if (c <= 14) w = {w[12:0], dout};
      if (fso === 1'b1) n++;
    end
    check("audio word", w, smp);
    check("frame sync duty", n, 32);
    wr_reg(7'h26, 8'h00);
    wr_reg(7'h35, 8'h10);
    rd_reg(7'h1E);
    c = b;
    wr_reg(7'h26, 8'h0C);
    repeat (1024) @(posedge clk);
    #1 wr_reg(7'h26, 8'h00);
    rd_reg(7'h1E);
    check("locked sample rate", b - c >= 2 && b - c <= 3, 1'b1);
    en = 1'b0;
    wr_reg(7'h35, 8'h80);
    check("frame sync follower", fsoe, 1'b0);
    wr_reg(7'h50, 8'h40);
    check("equaliser off", eqb, 1'b1);
    wr_reg(7'h27, 8'h74);
    check("double rate on", dbl, 1'b1);
    wr_reg(7'h27, 8'h70);
    check("double rate off", dbl, 1'b0);
    wr_reg(7'h26, 8'h2C);
    check("density bypass", fb, 1'b1);
    wr_reg(7'h26, 8'h00);
    complete_run();
  end
endmodule : accel_fifo_audio_port_config_tb_top
